/* File: fec_cfg.svh */
// fec_cfg.svh: offsets, field positions, reset values and sizes of the flash erase control block.
// assumes: included by bare name from the package and the control and protect decode modules.
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

`define FEC_ADDR_W 18
`define FEC_IDX_CTRL 16'hFE08
`define FEC_IDX_PROT 16'hFF7E
`define FEC_IDX_BASE 16'hE000
`define FEC_IDX_BASE_SMALL 16'hEE00
`define FEC_IDX_USER_END 16'hFDFF
`define FEC_IDX_VEC_BASE 16'hFFDC
`define FEC_ARRAY_DEPTH 8192
`define FEC_PAGE_BYTES 64
`define FEC_USER_BYTES_LARGE 7680
`define FEC_USER_BYTES_SMALL 4096
`define FEC_VEC_BYTES 36
`define FEC_CTRL_W 4
`define FEC_CTRL_RST 4'h0
`define FEC_ERASED_BYTE 8'hFF
`define FEC_PROT_NONE 8'hFF

`endif

/* File: fec_erase_walker.sv */
// fec_erase_walker.sv: steps through a span of array locations, one per cycle, to erase them.
// assumes: start is a one-cycle pulse given only while not busy.
`timescale 1ns/100ps
`default_nettype none

module fec_erase_walker #(
    parameter int AW = 13
)
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic start, // begin a span
    input wire logic [AW-1:0] base, // first location
    input wire logic [AW:0] count, // locations in span
    output logic busy, // erase write this cycle
    output logic [AW-1:0] addr // location being erased
);
    import fec_pkg::*;

    logic [AW-1:0] addr_q, addr_d;
    logic [AW:0] left_q, left_d;

    always_comb
    begin
        addr_d = addr_q;
        left_d = left_q;
        if (start)
        begin
            addr_d = base;
            left_d = count;
        end
        else if (left_q != '0)
        begin
            addr_d = addr_q + 1'b1;
            left_d = left_q - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_q <= '0;
            left_q <= '0;
        end
        else
        begin
            addr_q <= addr_d;
            left_q <= left_d;
        end
    end

    assign busy = (left_q != '0);
    assign addr = addr_q;

endmodule : fec_erase_walker

`default_nettype wire

/* File: fec_flash_erase_control.sv */
// fec_flash_erase_control.sv: flash array with its control register and erase/program sequencer, on APB.
// assumes: APB master holds each request until pready; array at index E000 upward, byte address is index times four.
//
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fec_cfg.svh"

module fec_flash_erase_control #(
    parameter bit SMALL_PART = 1'b0,
    parameter bit BLANK_AT_RESET = 1'b0,
    parameter int DEPTH = `FEC_ARRAY_DEPTH,
    parameter int PAGE = `FEC_PAGE_BYTES
)
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [`FEC_ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic charge_pump_on, // high voltage to array
    output fec_pkg::fec_stat_t status // sequencer status
);
    import fec_pkg::*;

    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH != `FEC_ARRAY_DEPTH || PAGE != `FEC_PAGE_BYTES)
        begin : g_bad_size
            $error("array depth and page size are fixed by the address map");
        end
    endgenerate

    // index to array offset, used by read, latch and program paths
    function automatic logic [AW-1:0] arr_off(input logic [15:0] i);
        logic [15:0] d;
        d = i - `FEC_IDX_BASE;
        return d[AW-1:0];
    endfunction : arr_off

    function automatic logic in_array(input logic [15:0] i);
        logic [15:0] lo;
        lo = SMALL_PART ? `FEC_IDX_BASE_SMALL : `FEC_IDX_BASE;
        return (i >= lo && i <= `FEC_IDX_USER_END) || i == `FEC_IDX_PROT
            || i >= `FEC_IDX_VEC_BASE;
    endfunction : in_array

    // sequencer has passed the protect check and holds a target
    function automatic logic seq_latched(input fec_seq_t s);
        return (s == SEQ_LATCHED) || (s == SEQ_HV);
    endfunction : seq_latched

    // nonvolatile contents: no reset on purpose
    logic [7:0] mem [DEPTH];

    fec_ctrl_t ctrl_q, ctrl_d, wr_ctrl;
    fec_seq_t seq_q, seq_d;
    logic [AW-1:0] page_q, page_d;
    logic mass_op_q, mass_op_d;
    logic stall_q;
    logic init_q;
    logic [31:0] prdata_q, prdata_d;

    logic [15:0] idx;
    logic is_ctrl, is_arr, aligned, mapped, stall, done, wr, rd;
    logic [AW-1:0] off;
    logic [7:0] rd_byte;
    logic hv_blocked, wr_blocked;
    logic [7:0] prot_byte;
    logic walk_start, walk_busy, prog_wr;
    logic [AW-1:0] walk_base, walk_addr;
    logic [AW:0] walk_count;

    // bus decode
    assign idx = paddr[`FEC_ADDR_W-1:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign is_ctrl = (idx == `FEC_IDX_CTRL);
    assign is_arr = ~is_ctrl & in_array(idx);
    assign mapped = aligned & (is_ctrl | is_arr);
    assign off = arr_off(idx);

    // array accesses wait while an erase sweeps the array; one extra cycle lets read data settle
    assign stall = psel & mapped & is_arr & walk_busy;
    assign pready = ~(stall | (psel & stall_q));
    assign done = psel & penable & pready;
    assign pslverr = done & ~mapped;
    assign wr = done & pwrite & mapped & pstrb[0];
    assign rd = done & ~pwrite & mapped;

    // control reads back its four bits; an index outside control and array reads zero, whatever the low address bits
    always_comb
    begin
        rd_byte = 8'h00;
        if (is_ctrl)
        begin
            rd_byte = {4'h0, ctrl_q};
        end
        else if (is_arr)
        begin
            rd_byte = mem[off];
        end
    end

    always_comb
    begin
        prdata_d = prdata_q;
        if (psel)
        begin
            prdata_d = {24'h000000, rd_byte};
        end
    end

    // the protect byte lives in the array, so a program of it takes effect at once
    assign prot_byte = mem[arr_off(`FEC_IDX_PROT)];

    // protection checks: latched target for high voltage, bus address for programming
    fec_prot_decode u_prot_hv (
        .prot_byte(prot_byte),
        .idx(page_q + `FEC_IDX_BASE),
        .mass(mass_op_q),
        .blocked(hv_blocked)
    );

    fec_prot_decode u_prot_wr (
        .prot_byte(prot_byte),
        .idx(idx),
        .mass(1'b0),
        .blocked(wr_blocked)
    );

    assign wr_ctrl = fec_ctrl_t'(pwdata[`FEC_CTRL_W-1:0]);

    // control register and sequencer
    always_comb
    begin
        ctrl_d = ctrl_q;
        seq_d = seq_q;
        page_d = page_q;
        mass_op_d = mass_op_q;
        walk_start = 1'b0;
        prog_wr = 1'b0;

        if (wr && is_ctrl)
        begin
            // a write asking for both selects changes neither
            if (!(wr_ctrl.erase && wr_ctrl.program_select))
            begin
                ctrl_d.erase = wr_ctrl.erase;
                ctrl_d.program_select = wr_ctrl.program_select;
            end
            ctrl_d.mass = wr_ctrl.mass;
            if (!wr_ctrl.high_voltage_enable)
            begin
                ctrl_d.high_voltage_enable = 1'b0;
            end
            else if ((ctrl_d.erase || ctrl_d.program_select) && seq_q == SEQ_LATCHED && !hv_blocked)
            begin
                ctrl_d.high_voltage_enable = 1'b1;
            end
        end

        // erase lands when the erase select drops under high voltage
        if (seq_q == SEQ_HV && ctrl_q.high_voltage_enable && ctrl_q.erase && !ctrl_d.erase && !walk_busy)
        begin
            walk_start = 1'b1;
        end

        // programming can only clear bits
        if (wr && is_arr && seq_q == SEQ_HV && ctrl_q.program_select && ctrl_q.high_voltage_enable && !wr_blocked && !walk_busy)
        begin
            prog_wr = 1'b1;
        end

        unique case (seq_q)
            SEQ_IDLE:
            begin
                if (ctrl_d.erase || ctrl_d.program_select)
                begin
                    seq_d = SEQ_SELECTED;
                end
            end
            SEQ_SELECTED:
            begin
                if (rd && is_arr && idx == `FEC_IDX_PROT)
                begin
                    seq_d = SEQ_CHECKED;
                end
            end
            SEQ_CHECKED:
            begin
                // any array location qualifies, the protect byte too
                if (wr && is_arr)
                begin
                    seq_d = SEQ_LATCHED;
                    page_d = off;
                    mass_op_d = ctrl_q.mass & ctrl_q.erase;
                end
            end
            SEQ_LATCHED:
            begin
                if (ctrl_d.high_voltage_enable)
                begin
                    seq_d = SEQ_HV;
                end
            end
            SEQ_HV:
            begin
                if (!ctrl_d.high_voltage_enable)
                begin
                    seq_d = (ctrl_d.erase || ctrl_d.program_select) ? SEQ_SELECTED : SEQ_IDLE;
                end
            end
        endcase

        // a changed selection without high voltage needs a fresh protect read and target,
        // so a stale latch from an abandoned attempt cannot gate the next one
        if (wr && is_ctrl && !ctrl_d.high_voltage_enable && (ctrl_d.erase != ctrl_q.erase || ctrl_d.program_select != ctrl_q.program_select
            || ctrl_d.mass != ctrl_q.mass))
        begin
            seq_d = SEQ_SELECTED;
        end

        // dropping both selects before high voltage abandons the sequence
        if (!ctrl_d.erase && !ctrl_d.program_select && !ctrl_d.high_voltage_enable)
        begin
            seq_d = SEQ_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= fec_ctrl_t'(`FEC_CTRL_RST);
            seq_q <= SEQ_IDLE;
            page_q <= '0;
            mass_op_q <= 1'b0;
            stall_q <= 1'b0;
            init_q <= BLANK_AT_RESET;
            prdata_q <= 32'h00000000;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            seq_q <= seq_d;
            page_q <= page_d;
            mass_op_q <= mass_op_d;
            stall_q <= stall;
            init_q <= 1'b0;
            prdata_q <= prdata_d;
        end
    end

    // page erase starts on its 64-byte boundary; mass and blank-at-reset sweep everything
    always_comb
    begin
        walk_base = {page_q[AW-1:6], 6'h00};
        walk_count = (AW+1)'(PAGE);
        if (mass_op_q || init_q)
        begin
            walk_base = '0;
            walk_count = (AW+1)'(DEPTH);
        end
    end

    fec_erase_walker #(.AW(AW)) u_walker (
        .pclk(pclk),
        .presetn(presetn),
        .start(walk_start | init_q),
        .base(walk_base),
        .count(walk_count),
        .busy(walk_busy),
        .addr(walk_addr)
    );

    always_ff @(posedge pclk)
    begin
        if (walk_busy)
        begin
            mem[walk_addr] <= `FEC_ERASED_BYTE;
        end
        else if (prog_wr)
        begin
            mem[off] <= mem[off] & pwdata[7:0];
        end
    end

    assign prdata = prdata_q;
    assign charge_pump_on = ctrl_q.high_voltage_enable;
    assign status.hv_on = ctrl_q.high_voltage_enable;
    assign status.erase_busy = walk_busy;
    assign status.prot_checked = (seq_q == SEQ_CHECKED) || seq_latched(seq_q);
    assign status.addr_latched = seq_latched(seq_q);

endmodule : fec_flash_erase_control

`default_nettype wire

/* File: fec_flash_erase_control_monitor.sv */
// fec_flash_erase_control_monitor.sv: port assertions for the flash erase control block.
// assumes: bound onto fec_flash_erase_control; one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
`include "fec_cfg.svh"
module fec_monitor #(
    parameter int DEPTH = `FEC_ARRAY_DEPTH,
    parameter int PAGE = `FEC_PAGE_BYTES
)
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // direction
    input wire logic [`FEC_ADDR_W-1:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [3:0] pstrb, // strobes
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic charge_pump_on, // pump
    input wire fec_pkg::fec_stat_t status // status
);
    import fec_pkg::*;
    logic ctl;
    logic arr;
    logic fin;
    logic wdone;
    logic [14:0] busy_d;
    logic [14:0] busy_q;
    assign ctl = paddr[17:2] == `FEC_IDX_CTRL;
    assign arr = paddr[17:2] >= `FEC_IDX_BASE && paddr[17:2] <= `FEC_IDX_USER_END && paddr[1:0] == 2'h0;
    assign fin = psel && penable && pready;
    assign wdone = fin && pwrite && pstrb[0] && ctl;
    // sweep length counter, cleared whenever the sweep is idle
    always_comb
    begin
        busy_d = status.erase_busy ? busy_q + 15'h1 : 15'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            busy_q <= 15'h0;
        else
            busy_q <= busy_d;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_pump_is_hv:
        assert property (charge_pump_on == status.hv_on) else $error("pump and hv status differ");
    a_hv_after_latch:
        assert property ($rose(charge_pump_on) |-> $past(status.addr_latched && status.prot_checked))
        else $error("pump rose without latched target");
    a_hv_by_write:
        assert property ($rose(charge_pump_on) |-> $past(wdone && pwdata[3])) else $error("pump rose without write");
    a_ctrl_readback:
        assert property (fin && !pwrite && ctl |-> prdata[1:0] != 2'h3 && prdata[3] == charge_pump_on)
        else $error("control readback wrong");
    a_reset_clear:
        assert property ($rose(presetn) |-> !charge_pump_on && status == '0) else $error("reset left state");
    a_sweep_len:
        assert property ($fell(status.erase_busy) |-> busy_q == PAGE || busy_q == DEPTH)
        else $error("sweep length wrong");
    a_sweep_cause:
        assert property ($rose(status.erase_busy) && charge_pump_on |-> $past(wdone && !pwdata[1]))
        else $error("sweep without erase clear");
    a_sweep_stall:
        assert property (psel && penable && arr && status.erase_busy |-> !pready) else $error("no stall in sweep");
    a_unmapped_err:
        assert property (fin && paddr[17:2] < `FEC_IDX_BASE |-> pslverr) else $error("unmapped without error");
endmodule : fec_monitor
`default_nettype wire

/* File: fec_flash_erase_control_tb.sv */
// fec_flash_erase_control_tb.sv: self-checking bench for the flash erase control block.
// assumes: array starts erased (BLANK_AT_RESET); bench is the only APB master.
`timescale 1ns/100ps
`default_nettype none
`include "fec_cfg.svh"
module fec_flash_erase_control_tb;
    import fec_pkg::*;
    localparam logic [15:0] CT = `FEC_IDX_CTRL;
    localparam logic [15:0] PR = `FEC_IDX_PROT;
    // software waits in 5 ns cycles; erase holds stay far below 1 ms and 4 ms to keep the run short,
    // which the design tolerates since it does not time them
    localparam int T_NVS = 2000;
    localparam int T_NVH = 1000;
    localparam int T_NVHL = 20000;
    localparam int T_RCV = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic charge_pump_on;
    fec_stat_t status;
    int error_cnt = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic er;
    typedef struct packed {logic [7:0] wd; logic [7:0] ex;} fec_row_t;
    // rows asking for both selects (03, 07, 0B) lean on the state left by the one before
    fec_row_t rows [8] = '{'{8'h01, 8'h01}, '{8'h03, 8'h01}, '{8'h07, 8'h05}, '{8'h08, 8'h00},
        '{8'h02, 8'h02}, '{8'h0B, 8'h02}, '{8'h0A, 8'h02}, '{8'h06, 8'h06}};
    always #2.5 pclk = ~pclk;
    fec_flash_erase_control #(.BLANK_AT_RESET(1'b1)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .charge_pump_on(charge_pump_on), .status(status));
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        if (got !== exp)
            error_cnt++;
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {ix, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // long waits only while an array access meets a full sweep
        while (pready !== 1'b1 && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000)
        begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdx(input logic [15:0] ix, input logic [7:0] ex);
        apb(1'b0, ix, 8'h00);
        chk(rd, {24'h0, ex});
    endtask : rdx
    task automatic arm(input logic [7:0] c, input logic [15:0] ix);
        apb(1'b1, CT, c);
        apb(1'b0, PR, 8'h00);
        apb(1'b1, ix, 8'h00);
        repeat (T_NVS) @(posedge pclk);
        apb(1'b1, CT, c | 8'h08);
    endtask : arm
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdx(CT, 8'h00);
        foreach (rows[i])
        begin
            apb(1'b1, CT, rows[i].wd);
            rdx(CT, rows[i].ex);
        end
        rdx(16'hE000, 8'hFF);
        arm(8'h01, 16'hE040);
        rdx(CT, 8'h09);
        apb(1'b1, 16'hE041, 8'h5A);
        apb(1'b1, 16'hE080, 8'h00);
        apb(1'b1, CT, 8'h08);
        apb(1'b1, CT, 8'h00);
        rdx(16'hE041, 8'h5A);
        arm(8'h02, 16'hE07F);
        apb(1'b1, CT, 8'h08);
        #1 chk({31'h0, status.erase_busy}, 32'h1);
        repeat (T_NVH) @(posedge pclk);
        apb(1'b1, CT, 8'h00);
        repeat (T_RCV) @(posedge pclk);
        rdx(16'hE041, 8'hFF);
        rdx(16'hE080, 8'h00);
        arm(8'h06, PR);
        apb(1'b1, CT, 8'h0C);
        repeat (T_NVHL) @(posedge pclk);
        apb(1'b1, CT, 8'h00);
        repeat (T_RCV) @(posedge pclk);
        rdx(16'hE080, 8'hFF);
        arm(8'h01, PR);
        apb(1'b1, PR, 8'hFE);
        apb(1'b1, CT, 8'h08);
        apb(1'b1, CT, 8'h00);
        rdx(PR, 8'hFE);
        arm(8'h02, 16'hFFDC);
        rdx(CT, 8'h02);
        chk({28'h0, status}, 32'h3);
        apb(1'b1, CT, 8'h00);
        arm(8'h06, 16'hE000);
        rdx(CT, 8'h06);
        apb(1'b0, 16'h0100, 8'h00);
        chk({31'h0, er}, 32'h1);
        arm(8'h02, 16'hE000);
        #1 chk({31'h0, charge_pump_on}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdx(CT, 8'h00);
        chk({31'h0, charge_pump_on}, 32'h0);
        complete_run();
    end
endmodule : fec_flash_erase_control_tb
bind fec_flash_erase_control fec_monitor #(.DEPTH(DEPTH), .PAGE(PAGE)) u_mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .charge_pump_on(charge_pump_on), .status(status));
`default_nettype wire

/* File: fec_pkg.sv */
// fec_pkg.sv: types shared by the flash erase control modules.
// assumes: fec_cfg.svh is on the include path.
`include "fec_cfg.svh"

package fec_pkg;

    // bit order matches the control register: 3 high voltage, 2 whole array, 1 erase, 0 program
    typedef struct packed {
        logic high_voltage_enable;
        logic mass;
        logic erase;
        logic program_select;
    } fec_ctrl_t;

    typedef enum logic [2:0] {SEQ_IDLE, SEQ_SELECTED, SEQ_CHECKED, SEQ_LATCHED, SEQ_HV} fec_seq_t;

    typedef struct packed {
        logic hv_on;
        logic erase_busy;
        logic prot_checked;
        logic addr_latched;
    } fec_stat_t;

endpackage : fec_pkg

/* File: fec_prot_decode.sv */
// fec_prot_decode.sv: decides whether an array location lies in the protected range.
// assumes: protect byte value comes straight from the array copy.
`timescale 1ns/100ps
`default_nettype none
`include "fec_cfg.svh"

module fec_prot_decode
(
    input wire logic [7:0] prot_byte, // protect start byte
    input wire logic [15:0] idx, // location index
    input wire logic mass, // whole array operation
    output logic blocked // operation refused
);
    import fec_pkg::*;

    logic [15:0] start;

    // byte holds address bits 13:6; 15:14 are one, 5:0 zero
    assign start = {2'b11, prot_byte, 6'h00};

    // all ones means nothing protected; any protection stops a mass erase
    assign blocked = (prot_byte != `FEC_PROT_NONE) && (mass || idx >= start);

endmodule : fec_prot_decode

`default_nettype wire
